//--- dwu_pkg.sv
package dwu_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_PERIOD   = 16'h008E;
  localparam logic [15:0] IDX_WDCTL    = 16'h00D8;
  localparam logic [15:0] IDX_IRQEN    = 16'h00E8;
  localparam logic [15:0] IDX_SLOWCFG  = 16'hA0D8;
  localparam logic [15:0] IDX_SLOWLO   = 16'hA0D9;
  localparam logic [15:0] IDX_SLOWHI   = 16'hA0DA;
  localparam int          ADDR_W       = 18;
  localparam int          IDX_LSB      = 2;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_PERIOD   = 8'hC4;
  localparam logic [7:0]  RST_WDCTL    = 8'h02;
  localparam logic [7:0]  RST_IRQEN    = 8'h00;
  localparam logic [7:0]  RST_SLOWCFG  = 8'hA7;
  localparam logic [7:0]  RST_SLOWHI   = 8'h0F;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int PER_SEL1       = 7;
  localparam int PER_SEL0       = 6;
  localparam int PER_TCTL_HI    = 5;
  localparam int PER_TCTL_LO    = 3;
  localparam int PER_SEL2       = 2;
  localparam int CTL_TMO_FLAG   = 3;
  localparam int CTL_RST_FLAG   = 2;
  localparam int CTL_RST_EN     = 1;
  localparam int CTL_RESTART    = 0;
  localparam int IRQEN_WD       = 4;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int MAIN_W   = 30;
  localparam int SLOW_W   = 16;
  localparam int PRE_W    = 15;

  // ----------------------------------------------------------------------
  // slow watchdog configuration layout
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       count_clear;
    logic       reset_en;
    logic       reset_flag;
    logic       irq_en;
    logic [2:0] clock_scale;
    logic       irq_flag;
  } dwu_slow_cfg_s;

  // main period exponent per timeout select code
  function automatic logic [4:0] dwu_main_exp(input logic [2:0] sel);
    logic [4:0] e;
    e = 5'h1E;
    unique case (sel)
      3'h0: e = 5'h11;
      3'h1: e = 5'h14;
      3'h2: e = 5'h17;
      3'h3: e = 5'h1A;
      3'h4: e = 5'h1B;
      3'h5: e = 5'h1C;
      3'h6: e = 5'h1D;
      3'h7: e = 5'h1E;
    endcase
    return e;
  endfunction : dwu_main_exp

  // slow prescaler exponent per clock scale code
  function automatic logic [3:0] dwu_slow_exp(input logic [2:0] cs);
    logic [3:0] e;
    e = 4'h8;
    unique case (cs)
      3'h4:    e = 4'hC;
      3'h5:    e = 4'hD;
      3'h6:    e = 4'hE;
      3'h7:    e = 4'hF;
      default: e = 4'h8;
    endcase
    return e;
  endfunction : dwu_slow_exp

endpackage : dwu_pkg

//--- dwu_counter.sv
`timescale 1ns/100ps
module dwu_counter
  import dwu_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         clr,
  input  wire logic         inc,
  output logic [W-1:0]      count_ff
);

  // ----------------------------------------------------------------------
  // up counter, clear wins
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_ff <= '0;
    else if (clr)
      count_ff <= '0;
    else if (inc)
      count_ff <= count_ff + W'(1);
  end

endmodule : dwu_counter

//--- dwu_edge_sync.sv
`timescale 1ns/100ps
module dwu_edge_sync
  import dwu_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      rise
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // ----------------------------------------------------------------------
  // two-stage synchroniser and rising edge detect
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign rise = sync_ff & ~last_ff;

endmodule : dwu_edge_sync

//--- dwu_top.sv
`timescale 1ns/100ps
//Contract
// - 30-bit main watchdog, interrupt or reset
// - main count holds while cpu clock gated
// - timeout flag set always, software clears
// - main interrupt gated by separate enable
// - reset flag set on wd reset
// - reset enable gates reset, default on
// - restart write zeroes count, not stored
// - restart only while timed access open
// - select picks period, default maximum
// - 16-bit slow watchdog on slow oscillator
// - count clear bit zeroes, self-clears
// - slow reset only when enabled
// - slow reset flag set, software clears
// - slow interrupt only when enabled
// - slow irq flag set, software clears
// - clock scale divides slow oscillator
// - slow event when count reaches timeout
// - timeout bytes read back current count
module dwu_top
  import dwu_pkg::*;
#(
  parameter logic [7:0] RST_SLOWLO = 8'hFF
)(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              cpu_clk_run,
  input  wire logic              timed_access_lock,
  input  wire logic              slow_oscillator,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   wd_irq,
  output logic                   slow_irq,
  output logic                   sys_reset_req,
  output logic [2:0]             timer_clock_ctl
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [7:0]          period_ff;
  logic                wd_timeout_flag_ff;
  logic                wd_reset_flag_ff;
  logic                wd_reset_enable_ff;
  logic                wd_irq_enable_ff;
  dwu_slow_cfg_s       slow_cfg_ff;
  logic [SLOW_W-1:0]   slow_timeout_ff;
  logic [PRE_W-1:0]    pre_ff;
  logic                ack_ff;
  logic [31:0]         avs_readdata_ff;
  logic                sys_reset_req_ff;
  logic                wd_irq_ff;
  logic                slow_irq_ff;
  logic [MAIN_W-1:0]   main_count;
  logic [SLOW_W-1:0]   slow_count;
  logic [MAIN_W-1:0]   main_limit;
  logic [PRE_W-1:0]    pre_mask;
  logic [15:0]         idx;
  logic                wr_go;
  logic                wr_lane;
  logic [7:0]          wbyte;
  logic [7:0]          nxt_rdata;
  logic [2:0]          wd_timeout_select;
  logic                main_tmo;
  logic                main_restart;
  logic                slow_tick;
  logic                slow_step;
  logic                slow_tmo;
  logic                slow_rst_ev;
  logic                slow_irq_ev;
  logic                main_rst_ev;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  assign idx             = avs_address[ADDR_W-1:IDX_LSB];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign wr_go           = avs_write & ack_ff;
  assign wr_lane         = wr_go & avs_byteenable[0];
  assign wbyte           = avs_writedata[7:0];
  assign avs_readdata    = avs_readdata_ff;

  // one wait cycle, then the answer stands for one cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
  end

  always_comb
  begin
    nxt_rdata = 8'h00;
    unique case (idx)
      IDX_PERIOD:  nxt_rdata = period_ff;
      IDX_WDCTL:   nxt_rdata = {4'h0, wd_timeout_flag_ff, wd_reset_flag_ff,
                                wd_reset_enable_ff, 1'b0};
      IDX_IRQEN:   nxt_rdata = 8'(wd_irq_enable_ff) << IRQEN_WD;
      IDX_SLOWCFG: nxt_rdata = {1'b0, slow_cfg_ff[6:0]};
      IDX_SLOWLO:  nxt_rdata = slow_count[7:0];
      IDX_SLOWHI:  nxt_rdata = slow_count[15:8];
      default:     nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      avs_readdata_ff <= 32'h0000_0000;
    else if (avs_read & ~ack_ff)
      avs_readdata_ff <= {24'h00_0000, nxt_rdata};
  end

  // ----------------------------------------------------------------------
  // main watchdog configuration
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      period_ff <= RST_PERIOD;
    else if (wr_lane && idx == IDX_PERIOD)
      period_ff <= {wbyte[7:2], 2'b00};
  end

  assign wd_timeout_select = {period_ff[PER_SEL2], period_ff[PER_SEL1],
                              period_ff[PER_SEL0]};
  assign timer_clock_ctl   = period_ff[PER_TCTL_HI:PER_TCTL_LO];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wd_reset_enable_ff <= RST_WDCTL[CTL_RST_EN];
    else if (wr_lane && idx == IDX_WDCTL)
      wd_reset_enable_ff <= wbyte[CTL_RST_EN];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wd_irq_enable_ff <= RST_IRQEN[IRQEN_WD];
    else if (wr_lane && idx == IDX_IRQEN)
      wd_irq_enable_ff <= wbyte[IRQEN_WD];
  end

  // ----------------------------------------------------------------------
  // main watchdog counter
  // ----------------------------------------------------------------------
  assign main_limit   = MAIN_W'((31'h1 << dwu_main_exp(wd_timeout_select)) - 31'h1);
  assign main_tmo     = cpu_clk_run & (main_count == main_limit);
  assign main_restart = wr_lane & (idx == IDX_WDCTL) & wbyte[CTL_RESTART]
                        & timed_access_lock;
  assign main_rst_ev  = main_tmo & wd_reset_enable_ff;

  dwu_counter #(
    .W        (MAIN_W)
  ) u_main_cnt (
    .clk      (clk),
    .reset_n  (reset_n),
    .clr      (main_tmo | main_restart | slow_rst_ev),
    .inc      (cpu_clk_run),
    .count_ff (main_count)
  );

  // timeout flag: hardware set wins over software write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wd_timeout_flag_ff <= RST_WDCTL[CTL_TMO_FLAG];
    else if (main_tmo)
      wd_timeout_flag_ff <= 1'b1;
    else if (wr_lane && idx == IDX_WDCTL)
      wd_timeout_flag_ff <= wbyte[CTL_TMO_FLAG];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wd_reset_flag_ff <= RST_WDCTL[CTL_RST_FLAG];
    else if (main_rst_ev)
      wd_reset_flag_ff <= 1'b1;
    else if (wr_lane && idx == IDX_WDCTL)
      wd_reset_flag_ff <= wbyte[CTL_RST_FLAG];
  end

  // ----------------------------------------------------------------------
  // slow watchdog prescaler
  // ----------------------------------------------------------------------
  dwu_edge_sync u_slow_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pin      (slow_oscillator),
    .rise     (slow_tick)
  );

  assign pre_mask  = PRE_W'((16'h1 << dwu_slow_exp(slow_cfg_ff.clock_scale)) - 16'h1);
  assign slow_step = slow_tick & ((pre_ff & pre_mask) == pre_mask);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pre_ff <= '0;
    else if (slow_cfg_ff.count_clear)
      pre_ff <= '0;
    else if (slow_tick)
      pre_ff <= pre_ff + PRE_W'(1);
  end

  // ----------------------------------------------------------------------
  // slow watchdog counter
  // ----------------------------------------------------------------------
  assign slow_tmo    = slow_step & (slow_count == slow_timeout_ff);
  assign slow_rst_ev = slow_tmo & slow_cfg_ff.reset_en;
  assign slow_irq_ev = slow_tmo & slow_cfg_ff.irq_en;

  dwu_counter #(
    .W        (SLOW_W)
  ) u_slow_cnt (
    .clk      (clk),
    .reset_n  (reset_n),
    .clr      (slow_cfg_ff.count_clear | slow_tmo),
    .inc      (slow_step),
    .count_ff (slow_count)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      slow_timeout_ff <= {RST_SLOWHI, RST_SLOWLO};
    else if (wr_lane && idx == IDX_SLOWLO)
      slow_timeout_ff[7:0] <= wbyte;
    else if (wr_lane && idx == IDX_SLOWHI)
      slow_timeout_ff[15:8] <= wbyte;
  end

  // ----------------------------------------------------------------------
  // slow watchdog configuration and flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      slow_cfg_ff.count_clear <= RST_SLOWCFG[7];
    else if (wr_lane && idx == IDX_SLOWCFG)
      slow_cfg_ff.count_clear <= wbyte[7];
    else
      slow_cfg_ff.count_clear <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slow_cfg_ff.reset_en    <= RST_SLOWCFG[6];
      slow_cfg_ff.irq_en      <= RST_SLOWCFG[4];
      slow_cfg_ff.clock_scale <= RST_SLOWCFG[3:1];
    end
    else if (wr_lane && idx == IDX_SLOWCFG)
    begin
      slow_cfg_ff.reset_en    <= wbyte[6];
      slow_cfg_ff.irq_en      <= wbyte[4];
      slow_cfg_ff.clock_scale <= wbyte[3:1];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      slow_cfg_ff.reset_flag <= RST_SLOWCFG[5];
    else if (slow_rst_ev)
      slow_cfg_ff.reset_flag <= 1'b1;
    else if (wr_lane && idx == IDX_SLOWCFG)
      slow_cfg_ff.reset_flag <= wbyte[5];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      slow_cfg_ff.irq_flag <= RST_SLOWCFG[0];
    else if (slow_irq_ev)
      slow_cfg_ff.irq_flag <= 1'b1;
    else if (wr_lane && idx == IDX_SLOWCFG)
      slow_cfg_ff.irq_flag <= wbyte[0];
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sys_reset_req_ff <= 1'b0;
      wd_irq_ff        <= 1'b0;
      slow_irq_ff      <= 1'b0;
    end
    else
    begin
      sys_reset_req_ff <= main_rst_ev | slow_rst_ev;
      wd_irq_ff        <= wd_timeout_flag_ff & wd_irq_enable_ff;
      slow_irq_ff      <= slow_cfg_ff.irq_flag & slow_cfg_ff.irq_en;
    end
  end

  assign sys_reset_req = sys_reset_req_ff;
  assign wd_irq        = wd_irq_ff;
  assign slow_irq      = slow_irq_ff;

endmodule : dwu_top

//--- dwu_top_properties.sv
`timescale 1ns/100ps
module dwu_top_properties
  import dwu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [31:0]       avs_readdata,
  input  wire logic              avs_waitrequest,
  input  wire logic              wd_irq,
  input  wire logic              slow_irq,
  input  wire logic              sys_reset_req,
  input  wire logic [2:0]        timer_clock_ctl
);
  // ----
  // accepted bus cycles
  // ----
  logic [15:0] idx;
  logic        acc_w;
  logic        acc_r;
  assign idx   = avs_address[ADDR_W-1:IDX_LSB];
  assign acc_w = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign acc_r = avs_read && !avs_waitrequest;

  default clocking dcb @(posedge clk); endclocking
  default disable iff (!reset_n);

  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait cycle on new request");
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  pulse_once_a: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request longer than one cycle");
  upper_zero_a: assert property (acc_r |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  write_only_a: assert property (acc_r |-> !(idx == IDX_WDCTL && avs_readdata[0]) &&
    !(idx == IDX_SLOWCFG && avs_readdata[7]))
    else $error("write only bit reads one");
  clkctl_set_a: assert property (acc_w && idx == IDX_PERIOD |=>
    timer_clock_ctl == $past(avs_writedata[5:3]))
    else $error("period register write not applied");
  wd_irq_clr_a: assert property (acc_w && (idx == IDX_WDCTL && !avs_writedata[CTL_TMO_FLAG] ||
    idx == IDX_IRQEN && !avs_writedata[IRQEN_WD]) |=> ##1 !wd_irq)
    else $error("main interrupt not cleared");
  slow_irq_clr_a: assert property (acc_w && idx == IDX_SLOWCFG &&
    !(avs_writedata[0] && avs_writedata[4]) |=> ##1 !slow_irq)
    else $error("slow interrupt not cleared");
endmodule : dwu_top_properties

bind dwu_top dwu_top_properties chk_u (
  .clk             (clk),
  .reset_n         (reset_n),
  .avs_address     (avs_address),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_writedata   (avs_writedata),
  .avs_byteenable  (avs_byteenable),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest),
  .wd_irq          (wd_irq),
  .slow_irq        (slow_irq),
  .sys_reset_req   (sys_reset_req),
  .timer_clock_ctl (timer_clock_ctl)
);

//--- testbench.sv
`timescale 1ns/100ps
module testbench;
  import dwu_pkg::*;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              cpu_clk_run = 1'b1;
  logic              timed_access_lock = 1'b0;
  logic              slow_oscillator = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'hF;
  logic [3:0]        be = 4'hF;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              wd_irq;
  logic              slow_irq;
  logic              sys_reset_req;
  logic [2:0]        timer_clock_ctl;
  logic [31:0]       seed = 32'h607D38B1;
  logic [31:0]       rd;
  logic [7:0]        m_cfg;
  logic [7:0]        to;
  logic              s_seen = 1'b0;
  int                n_fail = 0;
  int                n_checks = 0;
  int                n_rst = 0;
  int                n_edges = 0;
  int                cyc = 0;
  int                t0 = 0;
  int                ts = 0;
  int                tw = 0;

  dwu_top dut_u (
    .clk               (clk),
    .reset_n           (reset_n),
    .cpu_clk_run       (cpu_clk_run),
    .timed_access_lock (timed_access_lock),
    .slow_oscillator   (slow_oscillator),
    .avs_address       (avs_address),
    .avs_read          (avs_read),
    .avs_write         (avs_write),
    .avs_writedata     (avs_writedata),
    .avs_byteenable    (avs_byteenable),
    .avs_readdata      (avs_readdata),
    .avs_waitrequest   (avs_waitrequest),
    .wd_irq            (wd_irq),
    .slow_irq          (slow_irq),
    .sys_reset_req     (sys_reset_req),
    .timer_clock_ctl   (timer_clock_ctl)
  );

  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task chk_reg(input logic [31:0] act, input logic [31:0] exp);
    n_checks++;
    if (act !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask : chk_reg

  task chk_cnt(input int act, input int exp);
    n_checks++;
    if (act != exp)
    begin
      n_fail++;
      $display("mismatch t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask : chk_cnt

  task test_done;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // ----
  // bus cycles and slow clock
  // ----
  task bus(input logic w, input logic [15:0] i, input logic [7:0] d);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    t0 = cyc + 1;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task rreg(input logic [15:0] i, input logic [7:0] exp);
    bus(1'b0, i, 8'h00);
    chk_reg(rd, {24'h0, exp});
  endtask : rreg

  task tick;
    @(negedge clk);
    if (sys_reset_req === 1'b1)
      n_rst++;
    if (slow_irq === 1'b1)
      s_seen = 1'b1;
    if (wd_irq === 1'b1 && tw == 0)
      tw = cyc;
    @(posedge clk);
  endtask : tick

  task osc_edge;
    slow_oscillator <= 1'b1;
    repeat (5) tick;
    slow_oscillator <= 1'b0;
    repeat (5) tick;
    n_edges++;
  endtask : osc_edge

  initial
  begin
    repeat (200000) @(posedge clk);
    n_fail++;
    test_done;
  end

  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk_reg(timer_clock_ctl, 32'h0);
    rreg(IDX_PERIOD, RST_PERIOD);
    rreg(IDX_WDCTL, RST_WDCTL);
    rreg(IDX_IRQEN, RST_IRQEN);
    rreg(IDX_SLOWCFG, RST_SLOWCFG & 8'h7F);
    rreg(IDX_SLOWHI, 8'h00);
    bus(1'b1, 16'h0100, 8'hFF);
    rreg(16'h0100, 8'h00);
    be = 4'hE;
    bus(1'b1, IDX_PERIOD, 8'h00);
    be = 4'hF;
    rreg(IDX_PERIOD, RST_PERIOD);
    // ----
    // slow watchdog
    // ----
    seed = lfsr(seed);
    to = {7'h0, seed[0]} + 8'h02;
    m_cfg = {4'h5, 1'b0, seed[9:8], 1'b0};
    bus(1'b1, IDX_SLOWLO, to);
    bus(1'b1, IDX_SLOWHI, 8'h00);
    bus(1'b1, IDX_SLOWCFG, m_cfg | 8'h80);
    repeat (300) osc_edge;
    rreg(IDX_SLOWLO, 8'h01);
    rreg(IDX_SLOWHI, 8'h00);
    while (!s_seen && n_edges < 2000)
      osc_edge;
    chk_cnt(n_edges, (int'(to) + 1) * 256);
    chk_cnt(n_rst, 1);
    rreg(IDX_SLOWCFG, m_cfg | 8'h21);
    bus(1'b1, IDX_SLOWCFG, m_cfg);
    rreg(IDX_SLOWCFG, m_cfg);
    @(negedge clk);
    chk_reg({31'h0, slow_irq}, 32'h0);
    @(posedge clk);
    // ----
    // main watchdog
    // ----
    seed = lfsr(seed);
    bus(1'b1, IDX_PERIOD, {2'b00, seed[5:3], 3'b000});
    @(negedge clk);
    chk_reg(timer_clock_ctl, seed[5:3]);
    @(posedge clk);
    bus(1'b1, IDX_IRQEN, 8'h10);
    timed_access_lock <= 1'b1;
    bus(1'b1, IDX_WDCTL, 8'h03);
    ts = t0;
    timed_access_lock <= 1'b0;
    n_rst = 0;
    repeat (1000) tick;
    bus(1'b1, IDX_WDCTL, 8'h03);
    cpu_clk_run <= 1'b0;
    repeat (100) tick;
    cpu_clk_run <= 1'b1;
    while (tw == 0 && cyc - ts < 140000)
      tick;
    chk_cnt(tw - ts, 131072 + 1 + 100);
    repeat (3) tick;
    chk_cnt(n_rst, 1);
    rreg(IDX_WDCTL, 8'h0E);
    bus(1'b1, IDX_WDCTL, 8'h02);
    rreg(IDX_WDCTL, 8'h02);
    @(negedge clk);
    chk_reg({31'h0, wd_irq}, 32'h0);
    test_done;
  end
endmodule : testbench
